/* cidec_pkg.sv */
// package: constants and types of the instruction decoder
package cidec_pkg;
    localparam int PC_W = 21;
    localparam logic [3:0] OP_CLR = 4'h9;
    localparam logic [3:0] OP_SET = 4'h8;
    localparam logic [3:0] OP_FLIP = 4'h7;
    localparam logic [3:0] OP_SKIPLO = 4'hb;
    localparam logic [3:0] OP_SKIPHI = 4'ha;
    localparam logic [3:0] OP_REL = 4'hd;
    localparam logic [3:0] OP_BRGRP = 4'he;
    localparam logic [3:0] OP_OPND = 4'hf;
    localparam logic [3:0] OP_CTL = 4'h0;
    localparam logic [3:0] L_ADD = 4'hf;
    localparam logic [3:0] L_SUB = 4'h8;
    localparam logic [3:0] L_AND = 4'hb;
    localparam logic [3:0] L_OR = 4'h9;
    localparam logic [3:0] L_XOR = 4'ha;
    localparam logic [3:0] L_LOADW = 4'he;
    localparam logic [3:0] L_MUL = 4'hd;
    localparam logic [3:0] L_RETK = 4'hc;
    localparam logic [3:0] L_BANK = 4'h1;
    localparam logic [3:0] L_FIXED = 4'h0;
    localparam logic [3:0] B_JUMP = 4'hf;
    localparam logic [3:0] B_PTR = 4'he;
    localparam logic [2:0] B_CALL = 3'h6;
    localparam logic [7:0] F_STBY = 8'h03;
    localparam logic [7:0] F_WDT = 8'h04;
    localparam logic [7:0] F_PUSH = 8'h05;
    localparam logic [7:0] F_POP = 8'h06;
    localparam logic [7:0] F_DADJ = 8'h07;
    localparam logic [7:0] F_SWRST = 8'hff;
    localparam logic [6:0] F_IRET = 7'h08;
    localparam logic [6:0] F_SRET = 7'h09;
    localparam logic [4:0] F_TBL = 5'h01;
    localparam logic [1:0] TM_POSTINC = 2'h1;
    localparam logic [1:0] TM_POSTDEC = 2'h2;
    localparam logic [1:0] TM_PREINC = 2'h3;
    localparam logic [3:0] BCD_LIM = 4'h9;
    localparam logic [8:0] BCD_LO = 9'h006;
    localparam logic [8:0] BCD_HI = 9'h060;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_PCNT = 8'h04;
    localparam logic [7:0] A_CORE = 8'h08;
    localparam logic [7:0] A_TBL = 8'h0c;
    localparam logic [7:0] A_PTR01 = 8'h10;
    localparam logic [7:0] A_PTR2 = 8'h14;
    localparam logic [7:0] A_PROD = 8'h18;
    localparam logic RUN_RST = 1'b0;
    typedef struct packed {
        logic neg;
        logic ovf;
        logic zero;
        logic dcarry;
        logic carry;
    } cidec_flags_t;
    localparam cidec_flags_t FLAGS_RST = 5'h00;
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic we;
    } cidec_dreq_t;
    typedef enum logic [2:0] {
        S_EXEC = 3'b000,
        S_FLUSH = 3'b001,
        S_WORD2 = 3'b010,
        S_TABLE_READ_OP = 3'b011,
        S_TABLE_WRITE_OP = 3'b100,
        S_STBY = 3'b101
    } cidec_state_t;
endpackage : cidec_pkg

/* cidec_core.sv */
// instruction decoder and sequencer with ahb-lite register slave
// Overview of operation
// - top nibble picks bit clear, set, flip or skip tests; bit, access, file follow
// - bit skip costs one cycle, two over one word, three over two words
// - conditional branch 1110 0ccc with signed 8-bit offset; one or two cycles
// - relative jump and relative call take two; second cycle is a no-op
// - absolute jump and call are two words; second word holds high target bits
// - a lone second word executes as no-op; consumed only after its first
// - watchdog clear is one cycle, standby holds until WAKE; both update expiry, powerdown flags
// - push, pop, decimal adjust, software reset are single-cycle fixed codes
// - interrupt and subroutine return take two; s restores fast context
// - return with literal loads working register, two cycles, flags untouched
// - literal add, subtract, and, or, xor with their flag updates
// - literal load and literal multiply take one cycle, flags unchanged
// - bank select literal writes low four bank bits in one cycle
// - pointer load is two words forming a 12-bit value into selected pointer
// - table read two cycles, pointer none, post-inc, post-dec, pre-inc
// - table write two cycles plus any wait while TBL_BUSY is high, same four pointer modes
// - a started internal memory write runs until it completes
// - bit modify on the port register reads pin levels, not the latch
// - bit modify of timer zero clears its prescaler when assigned
// - all-zero word and top nibble 1111 run as one-cycle no-op
// - access bit 0 forces access bank, 1 uses bank select register
`timescale 1ns/1ps
module cidec_core #(
    parameter int STK_DEPTH = 31,
    parameter logic [11:0] PORT_ADDR = 12'h081,
    parameter logic [11:0] TIMER_ZERO_ADDR = 12'h056
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [cidec_pkg::PC_W-1:0] PROG_ADDR,
    input wire logic [15:0] PROG_DATA,
    output cidec_pkg::cidec_dreq_t DMEM_REQ,
    input wire logic [7:0] DMEM_RDATA,
    input wire logic [7:0] PORT_PINS,
    input wire logic PRESC_ASSIGNED,
    output logic PRESC_CLR,
    output logic [cidec_pkg::PC_W-1:0] TBL_ADDR,
    output logic TBL_WE,
    output logic [7:0] TBL_WDATA,
    input wire logic [7:0] TBL_RDATA,
    input wire logic TBL_BUSY,
    input wire logic WAKE,
    output logic STANDBY,
    output logic WDT_CLEAR,
    output logic SOFT_RESET,
    output logic [1:0] IRQ_ENABLE
);
    import cidec_pkg::*;
    localparam int SP_W = $clog2(STK_DEPTH + 1);

    cidec_state_t st_reg, st_next;
    logic [PC_W-1:0] program_counter_reg, pc_next, next_addr, br_tgt, rel_tgt, push_val;
    logic [PC_W-1:0] stack_top, tblptr_reg;
    logic [PC_W-1:0] stk_mem [0:STK_DEPTH-1];
    logic [SP_W-1:0] sp_reg;
    logic [15:0] iw, ir_reg, ir_next, prod_reg, prod_next;
    logic [7:0] working_register_reg, w_next, lit, rd_val, bmask, b_op, tablat_reg;
    logic [3:0] bank_select_reg, bsr_next;
    logic [11:0] bit_addr;
    logic [11:0] pointer_reg [0:2];
    logic [16:0] shadow_reg;
    cidec_flags_t flags_reg, fl_next;
    logic [8:0] sum9, dadj1, dadj;
    logic [4:0] h5;
    logic skip_reg, skip_next, run_reg, ex_now, taken, cnd, aov, is_sub;
    logic push, pop, fast_save, fast_rest, wdt_clr, stby, sw_reset, iret;
    logic tbl_go, tbl_wr, ptr_ld, presc_clr, expiry_flag_reg, powerdown_flag_reg;
    logic [1:0] irq_en_reg;
    logic wr_pend_reg;
    logic [7:0] wa_reg;
    logic [31:0] rd_mux, hrdata_reg;
    cidec_dreq_t dreq;

    assign iw = PROG_DATA;
    assign lit = iw[7:0];
    assign next_addr = program_counter_reg + PC_W'(2);
    assign br_tgt = next_addr + PC_W'($signed({iw[7:0], 1'b0}));
    assign rel_tgt = next_addr + PC_W'($signed({iw[10:0], 1'b0}));
    assign stack_top = (sp_reg == '0) ? '0 : stk_mem[sp_reg - 1'b1];
    assign ex_now = (st_reg == S_EXEC) && run_reg && !skip_reg;
    assign bit_addr = iw[8] ? {bank_select_reg, iw[7:0]} : {4'h0, iw[7:0]};
    assign rd_val = (bit_addr == PORT_ADDR) ? PORT_PINS : DMEM_RDATA;
    assign bmask = 8'h01 << iw[11:9];
    assign cnd = (iw[10:9] == 2'b00) ? flags_reg.zero :
                 (iw[10:9] == 2'b01) ? flags_reg.carry :
                 (iw[10:9] == 2'b10) ? flags_reg.ovf : flags_reg.neg;
    assign taken = cnd ^ iw[8];
    assign is_sub = (iw[11:8] == L_SUB);
    assign b_op = is_sub ? ~working_register_reg : working_register_reg;
    assign sum9 = {1'b0, lit} + {1'b0, b_op} + {8'h00, is_sub};
    assign h5 = {1'b0, lit[3:0]} + {1'b0, b_op[3:0]} + {4'h0, is_sub};
    assign aov = (lit[7] == b_op[7]) && (sum9[7] != lit[7]);
    assign dadj1 = {1'b0, working_register_reg} +
                   ((working_register_reg[3:0] > BCD_LIM || flags_reg.dcarry) ? BCD_LO : '0);
    assign dadj = dadj1 + ((dadj1[7:4] > BCD_LIM || flags_reg.carry) ? BCD_HI : '0);

    // decode and sequencing
    always_comb begin
        pc_next = program_counter_reg;
        st_next = st_reg;
        skip_next = skip_reg;
        w_next = working_register_reg;
        fl_next = flags_reg;
        bsr_next = bank_select_reg;
        prod_next = prod_reg;
        ir_next = ir_reg;
        dreq = '0;
        dreq.addr = bit_addr;
        push_val = next_addr;
        {push, pop, fast_save, fast_rest, wdt_clr, stby, sw_reset, iret} = '0;
        {tbl_go, tbl_wr, ptr_ld, presc_clr} = '0;
        unique case (st_reg)
            S_EXEC: if (run_reg) begin
                pc_next = next_addr;
                skip_next = 1'b0;
                if (!skip_reg) begin
                    case (iw[15:12])
                        OP_CLR, OP_SET, OP_FLIP: begin
                            dreq.we = 1'b1;
                            dreq.wdata = (iw[15:12] == OP_CLR) ? (rd_val & ~bmask) :
                                         (iw[15:12] == OP_SET) ? (rd_val | bmask) :
                                         (rd_val ^ bmask);
                            presc_clr = (bit_addr == TIMER_ZERO_ADDR) && PRESC_ASSIGNED;
                        end
                        OP_SKIPLO: skip_next = ~|(rd_val & bmask);
                        OP_SKIPHI: skip_next = |(rd_val & bmask);
                        OP_REL: begin
                            pc_next = rel_tgt;
                            push = iw[11];
                            st_next = S_FLUSH;
                        end
                        OP_BRGRP: begin
                            if (!iw[11]) begin
                                if (taken) begin
                                    pc_next = br_tgt;
                                    st_next = S_FLUSH;
                                end
                            end else if (iw[11:8] == B_JUMP || iw[11:9] == B_CALL ||
                                         (iw[11:8] == B_PTR && iw[7:6] == 2'b00)) begin
                                ir_next = iw;
                                st_next = S_WORD2;
                            end
                        end
                        OP_CTL: begin
                            if (iw[11:8] == L_FIXED) begin
                                case (iw[7:0])
                                    F_STBY: begin
                                        stby = 1'b1;
                                        st_next = S_STBY;
                                    end
                                    F_WDT: wdt_clr = 1'b1;
                                    F_PUSH: push = 1'b1;
                                    F_POP: pop = 1'b1;
                                    F_DADJ: begin
                                        w_next = dadj[7:0];
                                        fl_next.carry = flags_reg.carry | dadj[8];
                                    end
                                    F_SWRST: sw_reset = 1'b1;
                                    default: begin
                                        if (iw[7:1] == F_IRET || iw[7:1] == F_SRET) begin
                                            pc_next = stack_top;
                                            pop = 1'b1;
                                            fast_rest = iw[0];
                                            iret = (iw[7:1] == F_IRET);
                                            st_next = S_FLUSH;
                                        end else if (iw[7:3] == F_TBL) begin
                                            tbl_go = 1'b1;
                                            tbl_wr = iw[2];
                                            st_next = iw[2] ? S_TABLE_WRITE_OP : S_TABLE_READ_OP;
                                        end
                                    end
                                endcase
                            end else begin
                                case (iw[11:8])
                                    L_ADD, L_SUB: begin
                                        w_next = sum9[7:0];
                                        fl_next = '{neg: sum9[7], ovf: aov, zero: sum9[7:0] == 8'h00,
                                                    dcarry: h5[4], carry: sum9[8]};
                                    end
                                    L_AND, L_OR, L_XOR: begin
                                        w_next = (iw[11:8] == L_AND) ? (working_register_reg & lit) :
                                                 (iw[11:8] == L_OR) ? (working_register_reg | lit) :
                                                 (working_register_reg ^ lit);
                                        fl_next.zero = (w_next == 8'h00);
                                        fl_next.neg = w_next[7];
                                    end
                                    L_LOADW: w_next = lit;
                                    L_MUL: prod_next = {8'h00, working_register_reg} * {8'h00, lit};
                                    L_RETK: begin
                                        w_next = lit;
                                        pc_next = stack_top;
                                        pop = 1'b1;
                                        st_next = S_FLUSH;
                                    end
                                    L_BANK: if (iw[7:4] == 4'h0) bsr_next = iw[3:0];
                                    default: ;
                                endcase
                            end
                        end
                        default: ;
                    endcase
                end
            end
            S_FLUSH: st_next = S_EXEC;
            S_WORD2: begin
                pc_next = next_addr;
                st_next = S_EXEC;
                if (ir_reg[11:8] == B_PTR) begin
                    ptr_ld = 1'b1;
                end else begin
                    pc_next = {iw[11:0], ir_reg[7:0], 1'b0};
                    push = (ir_reg[11:9] == B_CALL);
                    fast_save = (ir_reg[11:9] == B_CALL) && ir_reg[8];
                end
            end
            S_TABLE_READ_OP: st_next = S_EXEC;
            S_TABLE_WRITE_OP: if (!TBL_BUSY) st_next = S_EXEC;
            S_STBY: if (WAKE) st_next = S_EXEC;
            default: st_next = S_EXEC;
        endcase
        if (fast_rest) begin
            {w_next, fl_next, bsr_next} = shadow_reg;
        end
    end

    // core state
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            program_counter_reg <= '0;
            st_reg <= S_EXEC;
            {ir_reg, prod_reg, shadow_reg} <= '0;
            {skip_reg, working_register_reg, bank_select_reg} <= '0;
            flags_reg <= FLAGS_RST;
            {expiry_flag_reg, powerdown_flag_reg} <= 2'b11;
        end else if (sw_reset) begin
            program_counter_reg <= '0;
            st_reg <= S_EXEC;
            {ir_reg, prod_reg, shadow_reg} <= '0;
            {skip_reg, working_register_reg, bank_select_reg} <= '0;
            flags_reg <= FLAGS_RST;
            {expiry_flag_reg, powerdown_flag_reg} <= 2'b11;
        end else begin
            program_counter_reg <= pc_next;
            st_reg <= st_next;
            ir_reg <= ir_next;
            skip_reg <= skip_next;
            working_register_reg <= w_next;
            flags_reg <= fl_next;
            bank_select_reg <= bsr_next;
            prod_reg <= prod_next;
            if (fast_save) shadow_reg <= {working_register_reg, flags_reg, bank_select_reg};
            if (wdt_clr || stby) begin
                expiry_flag_reg <= 1'b1;
                powerdown_flag_reg <= wdt_clr;
            end
        end
    end

    // return stack
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sp_reg <= '0;
        end else if (sw_reset) begin
            sp_reg <= '0;
        end else if (push && sp_reg < SP_W'(STK_DEPTH)) begin
            sp_reg <= sp_reg + 1'b1;
        end else if (pop && sp_reg != '0) begin
            sp_reg <= sp_reg - 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (push && sp_reg < SP_W'(STK_DEPTH)) stk_mem[sp_reg] <= push_val;
    end

    // pointers and table access
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pointer_reg <= '{default: '0};
            {tblptr_reg, tablat_reg, TBL_ADDR, TBL_WE, TBL_WDATA} <= '0;
        end else begin
            TBL_WE <= tbl_wr;
            if (ptr_ld && ir_reg[5:4] != 2'b11) pointer_reg[ir_reg[5:4]] <= {ir_reg[3:0], iw[7:0]};
            if (wr_pend_reg && wa_reg == A_TBL) {tablat_reg, tblptr_reg} <= HWDATA[28:0];
            if (st_reg == S_TABLE_READ_OP) tablat_reg <= TBL_RDATA;
            if (tbl_go) begin
                TBL_ADDR <= (iw[1:0] == TM_PREINC) ? tblptr_reg + 1'b1 : tblptr_reg;
                TBL_WDATA <= tablat_reg;
                if (iw[1:0] == TM_POSTINC || iw[1:0] == TM_PREINC) tblptr_reg <= tblptr_reg + 1'b1;
                if (iw[1:0] == TM_POSTDEC) tblptr_reg <= tblptr_reg - 1'b1;
            end
        end
    end

    // interrupt enables and event pulses
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            {irq_en_reg, WDT_CLEAR, SOFT_RESET} <= '0;
        end else begin
            WDT_CLEAR <= wdt_clr;
            SOFT_RESET <= sw_reset;
            if (sw_reset) irq_en_reg <= '0;
            else if (wr_pend_reg && wa_reg == A_CTRL) irq_en_reg <= HWDATA[2:1];
            if (iret) irq_en_reg[0] <= 1'b1;
        end
    end

    // ahb-lite slave, zero wait states
    always_comb begin
        rd_mux = '0;
        case (HADDR[7:0])
            A_CTRL: rd_mux = {29'h0, irq_en_reg, run_reg};
            A_PCNT: rd_mux = 32'(program_counter_reg);
            A_CORE: rd_mux = {10'h0, expiry_flag_reg, powerdown_flag_reg, bank_select_reg,
                              3'h0, flags_reg, working_register_reg};
            A_TBL: rd_mux = {3'h0, tablat_reg, tblptr_reg};
            A_PTR01: rd_mux = {4'h0, pointer_reg[1], 4'h0, pointer_reg[0]};
            A_PTR2: rd_mux = {20'(sp_reg), pointer_reg[2]};
            A_PROD: rd_mux = {16'h0, prod_reg};
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            {wr_pend_reg, wa_reg, hrdata_reg} <= '0;
            run_reg <= RUN_RST;
        end else begin
            wr_pend_reg <= HSEL && HTRANS[1] && HREADY && HWRITE;
            if (HSEL && HTRANS[1] && HREADY) begin
                wa_reg <= HADDR[7:0];
                hrdata_reg <= rd_mux;
            end
            if (wr_pend_reg && wa_reg == A_CTRL) run_reg <= HWDATA[0];
        end
    end

    assign HRDATA = hrdata_reg;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign PROG_ADDR = program_counter_reg;
    assign DMEM_REQ = dreq;
    assign PRESC_CLR = presc_clr;
    assign STANDBY = (st_reg == S_STBY);
    assign IRQ_ENABLE = irq_en_reg;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    a_rel_two_cycles: assert property (ex_now && iw[15:12] == OP_REL |=>
        st_reg == S_FLUSH ##1 st_reg == S_EXEC) else $error("relative jump not two cycles");
    a_branch_target: assert property (ex_now && iw[15:11] == 5'h1c && taken |=>
        st_reg == S_FLUSH && program_counter_reg == $past(br_tgt))
        else $error("taken branch target wrong");
    a_branch_untaken: assert property (ex_now && iw[15:11] == 5'h1c && !taken |=>
        st_reg == S_EXEC && program_counter_reg == $past(next_addr))
        else $error("untaken branch not one cycle");
    a_jump_two_word: assert property (ex_now && iw[15:8] == 8'hef |=>
        st_reg == S_WORD2 ##1 st_reg == S_EXEC) else $error("absolute jump not two words");
    a_lone_second: assert property (ex_now && iw[15:12] == OP_OPND |=>
        program_counter_reg == $past(next_addr) && $stable(working_register_reg))
        else $error("lone second word not idle");
    a_skip_consumes: assert property (skip_reg && st_reg == S_EXEC && run_reg |=>
        !skip_reg && $stable(working_register_reg) && $stable(flags_reg))
        else $error("skipped word had an effect");
    a_table_write_op_hold: assert property (st_reg == S_TABLE_WRITE_OP && TBL_BUSY |=>
        st_reg == S_TABLE_WRITE_OP && $stable(program_counter_reg)) else $error("table write cut short");
    a_presc_clear: assert property (PRESC_CLR |->
        DMEM_REQ.we && DMEM_REQ.addr == TIMER_ZERO_ADDR && PRESC_ASSIGNED)
        else $error("prescaler clear without timer write");
    a_port_pins: assert property (ex_now && iw[15:12] == OP_CLR && bit_addr == PORT_ADDR |->
        DMEM_REQ.wdata == (PORT_PINS & ~bmask)) else $error("port write used latch");
    a_ret_two: assert property (ex_now && iw[15:1] == 15'h0009 |=>
        st_reg == S_FLUSH && program_counter_reg == $past(stack_top))
        else $error("return not two cycles");
    a_loadw_flags: assert property (ex_now && iw[15:8] == 8'h0e |=>
        working_register_reg == $past(lit) && $stable(flags_reg))
        else $error("literal load wrong");

    c_skip_two_word: cover property (skip_reg && st_reg == S_EXEC && iw[15:8] == 8'hef);
    c_branch_taken: cover property (ex_now && iw[15:11] == 5'h1c && taken);
    c_table_write_op_wait: cover property (st_reg == S_TABLE_WRITE_OP && TBL_BUSY);
endmodule : cidec_core

/* cidec_mem.sv */
// partner model: program, data and table memory of the core
`timescale 1ns/1ps
module cidec_mem (
    input wire logic clk,
    input wire logic [cidec_pkg::PC_W-1:0] prog_addr,
    output logic [15:0] prog_data,
    input wire cidec_pkg::cidec_dreq_t dmem_req,
    output logic [7:0] dmem_rdata,
    input wire logic tbl_we,
    input wire logic [7:0] tbl_wdata,
    output logic [7:0] tbl_rdata,
    output logic tbl_busy
);
    import cidec_pkg::*;
    // initialisers run before any initial block, so the bench may load at time zero
    logic [15:0] rom [0:255] = '{default: 16'h0000};
    logic [7:0] ram [0:4095] = '{default: 8'h00};
    logic [7:0] tbl_last = 8'h00;
    logic [1:0] busy_cnt = 2'h0;
    assign prog_data = rom[prog_addr[8:1]];
    assign dmem_rdata = ram[dmem_req.addr];
    assign tbl_rdata = 8'h5a;
    // internal write cycle busy from the strobe on, for three cycles
    assign tbl_busy = tbl_we || busy_cnt != 2'h0;
    always @(posedge clk) begin
        if (dmem_req.we) begin
            ram[dmem_req.addr] <= dmem_req.wdata;
        end
        if (tbl_we) begin
            busy_cnt <= 2'h2;
            tbl_last <= tbl_wdata;
        end else if (busy_cnt != 2'h0) begin
            busy_cnt <= busy_cnt - 2'h1;
        end
    end
    task automatic load(input logic [7:0] idx, input logic [15:0] w);
        rom[idx] = w;
    endtask : load
endmodule : cidec_mem

/* cidec_core_tb_top.sv */
// testbench: runs a short program and checks state over the register bus
`timescale 1ns/1ps
module cidec_core_tb_top;
    import cidec_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, hrdy, hresp, tbl_busy;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_val;
    logic [PC_W-1:0] pa;
    logic [15:0] pd;
    logic [7:0] dr, tr, k, twd;
    logic [7:0] pins = 8'h00;
    logic presc = 1'b0, pclr, twe, wclr, rd_resp;
    logic [1:0] irq;
    cidec_dreq_t dq;
    logic [8:0] sum;
    logic [31:0] exp_q[$];
    int n_mismatch = 0, n_checks = 0, seed = 36;
    int n_pclr = 0, n_wclr = 0;
    event rd_done;
    always #50 clk = ~clk;
    cidec_core u_dut (.SYS_CLK(clk), .RST_N(rst_n), .HSEL(1'b1), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
        .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .PROG_ADDR(pa), .PROG_DATA(pd),
        .DMEM_REQ(dq), .DMEM_RDATA(dr), .PORT_PINS(pins), .PRESC_ASSIGNED(presc),
        .PRESC_CLR(pclr), .TBL_ADDR(), .TBL_WE(twe), .TBL_WDATA(twd), .TBL_RDATA(tr),
        .TBL_BUSY(tbl_busy), .WAKE(1'b0), .STANDBY(), .WDT_CLEAR(wclr), .SOFT_RESET(),
        .IRQ_ENABLE(irq));
    cidec_mem u_mem (.clk(clk), .prog_addr(pa), .prog_data(pd), .dmem_req(dq),
        .dmem_rdata(dr), .tbl_we(twe), .tbl_wdata(twd), .tbl_rdata(tr), .tbl_busy(tbl_busy));
    always @(posedge clk) if (pclr === 1'b1) n_pclr++;
    always @(posedge clk) if (wclr === 1'b1) n_wclr++;
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd_val = hrdata;
        rd_resp = hresp;
    endtask : ahb
    task automatic ahb_rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        ahb(1'b0, {24'h0, a}, 32'h0);
        -> rd_done;
    endtask : ahb_rd
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error hrdata expected %h seen %h", e, g);
        end
    endtask : chk
    task automatic chk_pin(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk_pin
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    initial forever begin
        @(rd_done);
        chk(exp_q.pop_front(), rd_val);
        chk_pin("hresp", 8'h00, {7'h0, rd_resp});
    end
    initial begin
        #(100 * 5000);
        n_mismatch++;
        close_out();
    end
    initial begin
        k = 8'($random(seed));
        sum = {1'b0, k} + 9'h015;
        u_mem.load(8'h00, {8'h0e, k});
        u_mem.load(8'h01, 16'h0f15);
        u_mem.load(8'h02, 16'hef08);
        u_mem.load(8'h03, 16'hf000);
        u_mem.load(8'h08, 16'h9081);
        u_mem.load(8'h09, 16'h8056);
        u_mem.load(8'h0a, 16'hee1a);
        u_mem.load(8'h0b, 16'hf05c);
        // zero and nonzero branches both land on the skip test
        u_mem.load(8'h0c, 16'he001);
        u_mem.load(8'h0d, 16'he100);
        // skipped or taken, the two-word jump lands on the call
        u_mem.load(8'h0e, 16'hb081);
        u_mem.load(8'h0f, 16'hef11);
        u_mem.load(8'h10, 16'hf000);
        u_mem.load(8'h11, 16'hd801);
        u_mem.load(8'h12, 16'hd7ff);
        u_mem.load(8'h13, 16'h0009);
        u_mem.load(8'h14, 16'h000c);
        u_mem.load(8'h15, 16'h0004);
        u_mem.load(8'h16, 16'h0012);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        pins <= 8'($random(seed));
        presc <= 1'b1;
        @(posedge clk);
        ahb(1'b1, {24'h0, A_CTRL}, 32'h7);
        repeat (40) @(posedge clk);
        ahb_rd(A_CTRL, 32'h7);
        ahb_rd(A_PCNT, 32'h24);
        ahb_rd(A_CORE, {12'h003, 7'h00, sum[7], ~k[7] & sum[7], sum[7:0] == 8'h00,
            ({1'b0, k[3:0]} + 5'h05) > 5'h0f, sum[8], sum[7:0]});
        ahb_rd(A_TBL, 32'h0b40_0001);
        ahb_rd(A_PTR01, 32'h0a5c_0000);
        ahb_rd(A_PTR2, 32'h0);
        ahb_rd(8'h1c, 32'h0);
        @(posedge clk);
        chk_pin("port_byte", pins & 8'hfe, u_mem.ram[12'h081]);
        chk_pin("timer_byte", 8'h01, u_mem.ram[12'h056]);
        chk_pin("presc_clr", 8'h01, 8'(n_pclr));
        chk_pin("wdt_clear", 8'h01, 8'(n_wclr));
        chk_pin("tbl_wdata", 8'h5a, u_mem.tbl_last);
        chk_pin("irq_enable", 8'h03, {6'h0, irq});
        close_out();
    end
endmodule : cidec_core_tb_top
